// >>> hcc_params.svh
// Constants for the serial channel control register block
`ifndef HCC_PARAMS_SVH
`define HCC_PARAMS_SVH
// ********************
// Register map
// ********************
`define HCC_ADDR_CTRL      8'h00
`define HCC_ADDR_STAT      8'h04
`define HCC_ADDR_PRMB      8'h08
`define HCC_CTRL_RST       32'h00000000
`define HCC_CTRL_WMASK     32'h1FFFFFFF
`define HCC_PRMB_RST       8'h00
// ********************
// Field positions
// ********************
`define HCC_B_TRANSMITTER_ON         0
`define HCC_B_RECEIVER_ON         1
`define HCC_B_DTXEN        6
`define HCC_B_DRXEN        7
`define HCC_B_TXSTSK       14
`define HCC_B_RXSTSK       15
`define HCC_B_RXDEC        16
`define HCC_B_FLAG         17
`define HCC_B_SFLAG        18
`define HCC_B_LOOP         19
`define HCC_B_ECHO         20
`define HCC_B_ABTEXT       21
`define HCC_B_ABT          22
`define HCC_B_PRMB         23
`define HCC_B_DTR          24
`define HCC_B_DISCON       25
`define HCC_B_TX_FCS_SUPPRESS      26
`define HCC_B_RX_FCS_CHECK_OFF      27
`define HCC_B_AUTO         28
// ********************
// Line patterns and counts
// ********************
`define HCC_FLAG_BYTE      8'h7E
`define HCC_MARK_BYTE      8'hFF
`define HCC_ABT_SHORT      5'h08
`define HCC_ABT_LONG       5'h10
`define HCC_RESP_OKAY      2'h0
`define HCC_RESP_SLVERR    2'h2
`endif

// >>> hcc_pkg.sv
// Types for the serial channel control register block
package hcc_pkg;
  // Transmit line state
  typedef enum logic [2:0] {
    HCC_TX_IDLE  = 3'b000,
    HCC_TX_OPEN  = 3'b001,
    HCC_TX_DATA  = 3'b010,
    HCC_TX_FCS   = 3'b011,
    HCC_TX_CLOSE = 3'b100,
    HCC_TX_ABORT = 3'b101,
    HCC_TX_PRMB  = 3'b110
  } hcc_tx_state_t;
  // Decoded controls toward the channel datapath
  typedef struct packed {
    logic rx_dma_addr_down;
    logic rx_fcs_check_off;
    logic tx_fcs_suppress;
    logic shared_delimiter;
    logic rx_dma_on;
    logic tx_dma_on;
    logic tx_clear;
    logic rx_clear;
    logic rx_discard;
  } hcc_ctl_t;
endpackage

// >>> hcc_channel_control.sv
// Upper channel control register and line sequencing for one framing channel
// Operation
// R1: Rx stop/skip disables Rx DMA without ownership
// R2: Address direction selects decrement or increment
// R3: Idle fill sends flag 7E or mark FF
// R4: Idle pattern persists until frame data
// R5: Shared delimiter uses one flag between frames; code still sends closing flag, one idle byte, then opening flag
// R6: Loop-back routes Tx to Rx, ignores handshakes
// R7: Auto-echo drives Tx pin from Rx pin
// R8: Abort sends eight ones, clears queue, self-clears; code sends sixteen ones
// R9: Abort extension sends sixteen ones, then mark; code sends twenty-four ones, one idle byte, then mark
// R10: Preamble replaces idle, interrupt mode only
// R11: Terminal-ready bit drives active-low pin
// R12: Discard drops current frame, self-clears next cycle
// R13: Discard never affects later frames
// R14: Fcs suppress omits appended check sequence
// R15: Check off skips CRC; CRC bytes stored
// R16: Handshake inputs act only with both enables
// R17: Auto off: CTS high forces mark idle
// R18: Auto on: CTS high clears Tx side
// R19: Auto on: DCD high clears Rx side
// R20: Reserved bits read zero, writes ignored
// R21: Tx stop/skip disables Tx DMA without ownership
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "hcc_params.svh"
module hcc_channel_control #(
  parameter int PRMB_CNT_W = 4
) (
  // Clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_N_I,
  // AXI4-Lite slave
  input  wire logic [7:0]          AWADDR_I,
  input  wire logic                AWVALID_I,
  output logic                     AWREADY_O,
  input  wire logic [31:0]         WDATA_I,
  input  wire logic [3:0]          WSTRB_I,
  input  wire logic                WVALID_I,
  output logic                     WREADY_O,
  output logic [1:0]               BRESP_O,
  output logic                     BVALID_O,
  input  wire logic                BREADY_I,
  input  wire logic [7:0]          ARADDR_I,
  input  wire logic                ARVALID_I,
  output logic                     ARREADY_O,
  output logic [31:0]              RDATA_O,
  output logic [1:0]               RRESP_O,
  output logic                     RVALID_O,
  input  wire logic                RREADY_I,
  // Channel datapath side
  input  wire logic                TX_DATA_VALID_I,
  input  wire logic [7:0]          TX_DATA_I,
  input  wire logic                TX_FRAME_END_I,
  output logic                     TX_DATA_TAKE_O,
  input  wire logic                RX_IN_FRAME_I,
  input  wire logic                TX_OWNED_I,
  input  wire logic                RX_OWNED_I,
  output hcc_pkg::hcc_ctl_t        CTL_O,
  // Serial pins
  input  wire logic                RXD_I,
  output logic                     TXD_O,
  output logic                     RX_BIT_O,
  input  wire logic                CLEAR_TO_SEND_IN_N_I,
  input  wire logic                CARRIER_DETECT_IN_N_I,
  output logic                     TERMINAL_READY_OUT_N_O
);
  initial
  begin
    if (PRMB_CNT_W < 1 || PRMB_CNT_W > 8)
      $error("PRMB_CNT_W out of range");
  end
  // ********************
  // Pin synchronisers
  // ********************
  logic [1:0] cts_sync;
  logic [1:0] dcd_sync;
  logic [1:0] rxd_sync;
  // Two flops per asynchronous input
  always_ff @(posedge REF_CLK_I)
  begin
    cts_sync <= {cts_sync[0], CLEAR_TO_SEND_IN_N_I};
    dcd_sync <= {dcd_sync[0], CARRIER_DETECT_IN_N_I};
    rxd_sync <= {rxd_sync[0], RXD_I};
  end
  // ********************
  // Registers
  // ********************
  logic [31:0]           channel_control;
  logic [7:0]            preamble_pattern;
  logic [PRMB_CNT_W-1:0] preamble_repeat_count;
  logic                  abort_done;
  logic                  discard_pend;
  wire transmitter_on = channel_control[`HCC_B_TRANSMITTER_ON];
  wire receiver_on    = channel_control[`HCC_B_RECEIVER_ON];
  wire auto_handshake = channel_control[`HCC_B_AUTO];
  wire local_loopback = channel_control[`HCC_B_LOOP];
  wire auto_echo      = channel_control[`HCC_B_ECHO];
  wire abort_request  = channel_control[`HCC_B_ABT];
  wire abort_extend   = channel_control[`HCC_B_ABTEXT];
  wire idle_fill_select = channel_control[`HCC_B_FLAG];
  wire tx_dma_mode    = channel_control[`HCC_B_DTXEN];
  // Handshakes gated by both enables and by loop-back
  wire hs_live = transmitter_on & receiver_on & ~local_loopback; // R6 R16
  wire cts_lost = hs_live & cts_sync[1];                         // R16 R17
  wire dcd_lost = hs_live & dcd_sync[1] & auto_handshake;        // R19
  // ********************
  // AXI4-Lite slave
  // ********************
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire do_write = aw_held & w_held & ~BVALID_O;
  wire wr_ctrl  = do_write & (aw_addr == `HCC_ADDR_CTRL);
  wire wr_prmb  = do_write & (aw_addr == `HCC_ADDR_PRMB);
  wire wr_ok    = (aw_addr == `HCC_ADDR_CTRL) |
                  (aw_addr == `HCC_ADDR_PRMB) |
                  (aw_addr == `HCC_ADDR_STAT);
  wire [31:0] bmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wmask = bmask & `HCC_CTRL_WMASK;                   // R20
  wire [31:0] stat_word = {26'h0, discard_pend, abort_done,
                           RX_IN_FRAME_I, ~dcd_sync[1],
                           ~cts_sync[1], TXD_O};
  wire [31:0] prmb_word = {{(24-PRMB_CNT_W){1'b0}}, preamble_repeat_count,
                           preamble_pattern};
  wire rd_ctrl = (ARADDR_I == `HCC_ADDR_CTRL);
  wire rd_stat = (ARADDR_I == `HCC_ADDR_STAT);
  wire rd_prmb = (ARADDR_I == `HCC_ADDR_PRMB);
  wire [31:0] rd_word = rd_ctrl ? channel_control :
                        rd_stat ? stat_word :
                        rd_prmb ? prmb_word : 32'h00000000;
  // Address and data capture, write response
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h00000000;
      w_strb   <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O  <= `HCC_RESP_OKAY;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (do_write)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O  <= wr_ok ? `HCC_RESP_OKAY : `HCC_RESP_SLVERR;
      end
      else if (BREADY_I)
        BVALID_O <= 1'b0;
    end
  end
  assign AWREADY_O = ~aw_held & ~BVALID_O & RST_N_I;
  assign WREADY_O  = ~w_held & ~BVALID_O & RST_N_I;
  // Read channel
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h00000000;
      RRESP_O   <= `HCC_RESP_OKAY;
      ARREADY_O <= 1'b0;
    end
    else
    begin
      ARREADY_O <= ~RVALID_O & ~ARREADY_O & ARVALID_I;
      if (ARVALID_I && ARREADY_O)
      begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_word;                                     // R20
        RRESP_O  <= (rd_ctrl | rd_stat | rd_prmb) ?
                    `HCC_RESP_OKAY : `HCC_RESP_SLVERR;
      end
      else if (RREADY_I)
        RVALID_O <= 1'b0;
    end
  end
  // ********************
  // Control register
  // ********************
  wire [31:0] ctrl_wr = (channel_control & ~wmask) | (w_data & wmask);
  logic [31:0] next_channel_control;
  logic        abort_clear;
  // Hardware clears: abort when sent, discard after one cycle
  always_comb
  begin
    next_channel_control = wr_ctrl ? ctrl_wr : channel_control;
    if (abort_clear)
      next_channel_control[`HCC_B_ABT] = 1'b0;                   // R8
    if (channel_control[`HCC_B_DISCON])
      next_channel_control[`HCC_B_DISCON] = 1'b0;                // R12
  end
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
      channel_control <= `HCC_CTRL_RST;
    else
      channel_control <= next_channel_control;
  end
  // Preamble register
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      preamble_pattern      <= `HCC_PRMB_RST;
      preamble_repeat_count <= '0;
    end
    else if (wr_prmb)
    begin
      if (w_strb[0])
        preamble_pattern <= w_data[7:0];
      if (w_strb[1])
        preamble_repeat_count <= w_data[8 +: PRMB_CNT_W];
    end
  end
  // ********************
  // Transmit sequencer
  // ********************
  hcc_pkg::hcc_tx_state_t tx_state;
  hcc_pkg::hcc_tx_state_t next_tx_state;
  logic [7:0]             tx_shift;
  logic [7:0]             next_tx_shift;
  logic [2:0]             bit_cnt;
  logic [4:0]             ones_cnt;
  logic [PRMB_CNT_W-1:0]  prmb_left;
  logic                   mark_after_abort;
  logic                   prev_closed;
  wire byte_end = (bit_cnt == 3'h7);
  wire [4:0] abort_len = abort_extend ? `HCC_ABT_LONG : `HCC_ABT_SHORT; // R9
  wire use_prmb = channel_control[`HCC_B_PRMB] & ~tx_dma_mode &
                  (prmb_left != '0);                             // R10
  wire force_mark = cts_lost | mark_after_abort;                 // R17 R18
  wire [7:0] idle_byte = (force_mark | ~idle_fill_select) ?
                         `HCC_MARK_BYTE : `HCC_FLAG_BYTE;        // R3
  wire tx_reset = cts_lost & auto_handshake;                     // R18
  assign abort_clear = (tx_state == hcc_pkg::HCC_TX_ABORT) &
                       (ones_cnt >= abort_len) & byte_end;       // R8
  // Byte-level choice of next line state
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_shift = {1'b1, tx_shift[7:1]};
    if (byte_end)
    begin
      next_tx_shift = idle_byte;                                 // R4
      case (tx_state)
        hcc_pkg::HCC_TX_IDLE, hcc_pkg::HCC_TX_PRMB:
        begin
          if (use_prmb && !TX_DATA_VALID_I)
          begin
            next_tx_state = hcc_pkg::HCC_TX_PRMB;
            next_tx_shift = preamble_pattern;                    // R10
          end
          else if (TX_DATA_VALID_I && !force_mark && transmitter_on)
          begin
            // Shared delimiter skips the opening state but still loads the flag byte
            next_tx_state = (prev_closed &&
                             channel_control[`HCC_B_SFLAG]) ?
                            hcc_pkg::HCC_TX_DATA :
                            hcc_pkg::HCC_TX_OPEN;                // R5
            next_tx_shift = `HCC_FLAG_BYTE;
          end
          else
            next_tx_state = hcc_pkg::HCC_TX_IDLE;
        end
        hcc_pkg::HCC_TX_OPEN, hcc_pkg::HCC_TX_DATA:
        begin
          next_tx_state = TX_FRAME_END_I ?
            (channel_control[`HCC_B_TX_FCS_SUPPRESS] ?
             hcc_pkg::HCC_TX_CLOSE : hcc_pkg::HCC_TX_FCS) :    // R14
            hcc_pkg::HCC_TX_DATA;
          next_tx_shift = TX_DATA_I;
        end
        hcc_pkg::HCC_TX_FCS:
        begin
          next_tx_state = hcc_pkg::HCC_TX_CLOSE;
          next_tx_shift = `HCC_FLAG_BYTE;
        end
        hcc_pkg::HCC_TX_CLOSE:
          next_tx_state = hcc_pkg::HCC_TX_IDLE;
        hcc_pkg::HCC_TX_ABORT:
          next_tx_state = abort_clear ? hcc_pkg::HCC_TX_IDLE :
                                        hcc_pkg::HCC_TX_ABORT;
        default:
          next_tx_state = hcc_pkg::HCC_TX_IDLE;
      endcase
      if (abort_request && !abort_clear)
      begin
        next_tx_state = hcc_pkg::HCC_TX_ABORT;                   // R8
        next_tx_shift = `HCC_MARK_BYTE;
      end
    end
  end
  // Bit shifting, abort counting, preamble repeats
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I || tx_reset)
    begin
      tx_state         <= hcc_pkg::HCC_TX_IDLE;
      tx_shift         <= `HCC_MARK_BYTE;
      bit_cnt          <= 3'h0;
      ones_cnt         <= 5'h00;
      mark_after_abort <= 1'b0;
      prev_closed      <= 1'b0;
      prmb_left        <= '0;
      abort_done       <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      bit_cnt  <= bit_cnt + 3'h1;
      if (tx_state == hcc_pkg::HCC_TX_ABORT && ones_cnt != 5'h1F)
        ones_cnt <= ones_cnt + 5'h01;
      else if (tx_state != hcc_pkg::HCC_TX_ABORT)
        ones_cnt <= 5'h00;
      if (abort_clear)
        mark_after_abort <= abort_extend;                        // R9
      else if (TX_DATA_VALID_I && tx_state == hcc_pkg::HCC_TX_IDLE)
        mark_after_abort <= 1'b0;
      abort_done <= abort_done | abort_clear;
      if (byte_end)
        prev_closed <= (tx_state == hcc_pkg::HCC_TX_CLOSE) &
                       TX_DATA_VALID_I;
      if (wr_prmb)
        prmb_left <= w_data[8 +: PRMB_CNT_W];
      else if (byte_end && next_tx_state == hcc_pkg::HCC_TX_PRMB)
        prmb_left <= prmb_left - 1'b1;
    end
  end
  // ********************
  // Pin and control outputs
  // ********************
  wire line_bit = tx_shift[0];
  wire take = byte_end & (next_tx_state == hcc_pkg::HCC_TX_DATA ||
              next_tx_state == hcc_pkg::HCC_TX_OPEN) & TX_DATA_VALID_I;
  // Registered pin and datapath controls
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      TXD_O                  <= 1'b1;
      RX_BIT_O               <= 1'b1;
      TX_DATA_TAKE_O         <= 1'b0;
      TERMINAL_READY_OUT_N_O <= 1'b1;
      CTL_O                  <= '0;
      discard_pend           <= 1'b0;
    end
    else
    begin
      TXD_O    <= auto_echo ? rxd_sync[1] : line_bit;            // R7
      RX_BIT_O <= local_loopback ? line_bit : rxd_sync[1];       // R6
      TX_DATA_TAKE_O <= take;
      TERMINAL_READY_OUT_N_O <= ~channel_control[`HCC_B_DTR];    // R11
      CTL_O.rx_dma_addr_down <= channel_control[`HCC_B_RXDEC];   // R2
      CTL_O.rx_fcs_check_off <= channel_control[`HCC_B_RX_FCS_CHECK_OFF]; // R15
      CTL_O.tx_fcs_suppress  <= channel_control[`HCC_B_TX_FCS_SUPPRESS]; // R14
      CTL_O.shared_delimiter <= channel_control[`HCC_B_SFLAG];
      CTL_O.tx_dma_on <= tx_dma_mode &
        ~(channel_control[`HCC_B_TXSTSK] & ~TX_OWNED_I);         // R21
      CTL_O.rx_dma_on <= channel_control[`HCC_B_DRXEN] &
        ~(channel_control[`HCC_B_RXSTSK] & ~RX_OWNED_I);         // R1
      CTL_O.tx_clear <= abort_request | tx_reset;                // R8 R18
      CTL_O.rx_clear <= dcd_lost;                                // R19
      // One-shot discard bound to the frame in progress
      CTL_O.rx_discard <= channel_control[`HCC_B_DISCON] &
                          RX_IN_FRAME_I;                         // R13
      discard_pend <= channel_control[`HCC_B_DISCON];
    end
  end
  // ********************
  // Assertions
  // ********************
  property p_dtr;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      ##1 $past(RST_N_I) |->
      TERMINAL_READY_OUT_N_O == !$past(channel_control[`HCC_B_DTR]);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr pin wrong"); // R11
  property p_discon_clear;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      channel_control[`HCC_B_DISCON] |=> !channel_control[`HCC_B_DISCON];
  endproperty
  a_discon_clear: assert property (p_discon_clear) // R12
    else $error("discard not cleared");
  property p_reserved;
    @(posedge REF_CLK_I) disable iff (!RST_N_I) channel_control[31:29] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) // R20
    else $error("reserved bits set");
  property p_rxdma;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      channel_control[`HCC_B_RXSTSK] && !RX_OWNED_I |=> !CTL_O.rx_dma_on;
  endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx dma on"); // R1
  property p_txdma;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      channel_control[`HCC_B_TXSTSK] && !TX_OWNED_I |=> !CTL_O.tx_dma_on;
  endproperty
  a_txdma: assert property (p_txdma) else $error("tx dma on"); // R21
  property p_abort_ones;
    @(posedge REF_CLK_I) disable iff (!RST_N_I || tx_reset)
      abort_clear |-> ones_cnt >= 5'h07;
  endproperty
  a_abort_ones: assert property (p_abort_ones) // R8
    else $error("abort too short");
  property p_loop;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      local_loopback |=> RX_BIT_O == $past(line_bit);
  endproperty
  a_loop: assert property (p_loop) else $error("loop path wrong"); // R6
  property p_dcd;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      !hs_live |=> !CTL_O.rx_clear;
  endproperty
  a_dcd: assert property (p_dcd) else $error("handshake acted"); // R16
  c_abort: cover property (@(posedge REF_CLK_I) abort_clear);
  c_prmb: cover property (@(posedge REF_CLK_I)
    tx_state == hcc_pkg::HCC_TX_PRMB);
  c_frame: cover property (@(posedge REF_CLK_I)
    tx_state == hcc_pkg::HCC_TX_CLOSE);
endmodule

// >>> hcc_modem_model.sv
// Remote station and modem model on the serial side of the channel
`timescale 1ns/1ns
module hcc_modem_model (
  // Clock
  input  wire logic       clk_i,
  // Bench controls
  input  wire logic       rx_level_i,
  input  wire logic       cts_drop_i,
  input  wire logic       dcd_drop_i,
  input  wire logic       run_clr_i,
  // Serial lines
  input  wire logic       txd_i,
  input  wire logic       rx_bit_i,
  output logic            rxd_o,
  output logic            cts_n_o,
  output logic            dcd_n_o,
  // Observations
  output logic [7:0]      tx_win_o,
  output logic [7:0]      rx_win_o,
  output logic [7:0]      max_run_o
);
  logic [7:0] run;
  // Line levels; a dropped handshake drives its pin high
  assign rxd_o   = rx_level_i;
  assign cts_n_o = cts_drop_i;
  assign dcd_n_o = dcd_drop_i;
  // Last eight bits seen and the longest run of ones
  always_ff @(posedge clk_i)
  begin
    tx_win_o <= {txd_i, tx_win_o[7:1]};
    rx_win_o <= {rx_bit_i, rx_win_o[7:1]};
    if (run_clr_i) run <= 8'h00;
    else run <= txd_i ? ((run == 8'hFF) ? run : run + 8'h01) : 8'h00;
    if (run_clr_i) max_run_o <= 8'h00;
    else if (run > max_run_o) max_run_o <= run;
  end
endmodule

// >>> hcc_channel_control_tb_top.sv
// Self-checking bench for the upper channel control block
`timescale 1ns/1ns
`include "hcc_params.svh"
module hcc_channel_control_tb_top;
  logic clk, rst_n, awv, wv, bry, arv, rry, rx_lvl, cts_d, dcd_d, rclr;
  logic rx_fr, tx_own, rx_own, awr, wr, bv, arr, rv, txd, rxb, rxd, ctsn;
  logic dcdn, dtrn, take;
  logic [7:0] awa, ara, twin, rwin, mrun;
  logic [31:0] wd, rd;
  logic [3:0] wst;
  logic [1:0] br, rr;
  hcc_pkg::hcc_ctl_t ctl;
  int error_cnt, num_checks, disc_cnt;
  localparam logic [31:0] EN = 32'h00000003;
  localparam logic [31:0] FLG = 32'h1 << `HCC_B_FLAG;
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  hcc_channel_control #(.PRMB_CNT_W(4)) DUT (
    .REF_CLK_I(clk), .RST_N_I(rst_n),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(wst), .WVALID_I(wv), .WREADY_O(wr), .BRESP_O(br),
    .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv),
    .RREADY_I(rry), .TX_DATA_VALID_I(1'b0), .TX_DATA_I(8'h00),
    .TX_FRAME_END_I(1'b0), .TX_DATA_TAKE_O(take), .RX_IN_FRAME_I(rx_fr),
    .TX_OWNED_I(tx_own), .RX_OWNED_I(rx_own), .CTL_O(ctl), .RXD_I(rxd),
    .TXD_O(txd), .RX_BIT_O(rxb), .CLEAR_TO_SEND_IN_N_I(ctsn),
    .CARRIER_DETECT_IN_N_I(dcdn), .TERMINAL_READY_OUT_N_O(dtrn));
  hcc_modem_model u_far (
    .clk_i(clk), .rx_level_i(rx_lvl), .cts_drop_i(cts_d),
    .dcd_drop_i(dcd_d), .run_clr_i(rclr), .txd_i(txd), .rx_bit_i(rxb),
    .rxd_o(rxd), .cts_n_o(ctsn), .dcd_n_o(dcdn), .tx_win_o(twin),
    .rx_win_o(rwin), .max_run_o(mrun));
  // Count discard pulses toward the receiver
  always @(posedge clk)
    if (ctl.rx_discard === 1'b1) disc_cnt++;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Write: offer address and data, release each when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      #19;
      ah = awv & awr; wh = wv & wr; bh = bv; r = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh) bry <= 1'b0;
      if (bh) break;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ah, vh;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      #19;
      ah = arv & arr; vh = rv; d = rd; r = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
      if (vh) rry <= 1'b0;
      if (vh) break;
    end
  endtask
  task automatic wctl(input logic [31:0] d);
    logic [1:0] r;
    axi_wr(`HCC_ADDR_CTRL, d, r);
  endtask
  task automatic rctl(output logic [31:0] d);
    logic [1:0] r;
    axi_rd(`HCC_ADDR_CTRL, d, r);
  endtask
  // Reset value, reserved bits and an unmapped address
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rctl(d);
    chk("ctrl reset", d, `HCC_CTRL_RST);
    wctl(32'hFFFFFFFF);
    rctl(d);
    chk("reserved bits", d & 32'hE0000000, 32'h0);
    axi_wr(8'h40, 32'h1, r);
    chk("unmapped resp", r, `HCC_RESP_SLVERR);
    wctl(32'h0);
  endtask
  // Idle fill flag or mark, kept while no frame is offered
  task automatic t_idle;
    wctl(32'h0);
    cyc(20);
    chk("mark idle", $countones(twin), 8);
    wctl(FLG);
    cyc(20);
    chk("flag idle", $countones(twin), 6);
    cyc(43);
    chk("flag kept", $countones(twin), 6);
  endtask
  // DMA stop/skip, address direction and frame options
  task automatic t_dma;
    wctl(32'h0C0DC0C0);
    cyc(4);
    chk("rx dma off", ctl.rx_dma_on, 0);
    chk("tx dma off", ctl.tx_dma_on, 0);
    chk("addr down", ctl.rx_dma_addr_down, 1);
    chk("fcs suppress", ctl.tx_fcs_suppress, 1);
    chk("fcs check off", ctl.rx_fcs_check_off, 1);
    chk("shared flag", ctl.shared_delimiter, 1);
    @(posedge clk) {tx_own, rx_own} <= 2'b11;
    cyc(4);
    chk("rx dma on", ctl.rx_dma_on, 1);
    chk("tx dma on", ctl.tx_dma_on, 1);
    wctl(32'h000000C0);
    cyc(4);
    chk("addr up", ctl.rx_dma_addr_down, 0);
  endtask
  task automatic t_dtr;
    wctl(32'h1 << `HCC_B_DTR);
    cyc(4);
    chk("dtr low", dtrn, 0);
    wctl(32'h0);
    cyc(4);
    chk("dtr high", dtrn, 1);
  endtask
  // Abort short and extended, self-clearing request
  task automatic t_abort(input logic ext, input logic [7:0] need);
    logic [31:0] d;
    wctl(FLG);
    @(posedge clk) rclr <= 1'b1;
    @(posedge clk) rclr <= 1'b0;
    wctl(FLG | (32'h1 << `HCC_B_ABT) | (32'(ext) << `HCC_B_ABTEXT));
    cyc(60);
    chk("abort ones", 32'(mrun >= need), 1);
    rctl(d);
    chk("abort cleared", d[`HCC_B_ABT], 0);
    if (ext) chk("mark after", $countones(twin), 8);
  endtask
  // Discard hits the frame in progress only
  task automatic t_discard;
    logic [31:0] d;
    @(posedge clk) rx_fr <= 1'b1;
    disc_cnt = 0;
    wctl(32'h1 << `HCC_B_DISCON);
    cyc(4);
    @(posedge clk) rx_fr <= 1'b0;
    @(posedge clk) rx_fr <= 1'b1;
    cyc(20);
    chk("discard once", disc_cnt, 1);
    rctl(d);
    chk("discard cleared", d[`HCC_B_DISCON], 0);
    @(posedge clk) rx_fr <= 1'b0;
  endtask
  // Handshake inputs with and without automatic mode, and loop-back
  task automatic t_modem;
    wctl(32'h1 << `HCC_B_AUTO);
    @(posedge clk) {cts_d, dcd_d} <= 2'b11;
    cyc(8);
    chk("no enables", ctl.rx_clear, 0);
    wctl((32'h1 << `HCC_B_AUTO) | FLG | EN);
    cyc(20);
    chk("dcd loss", ctl.rx_clear, 1);
    chk("cts loss", ctl.tx_clear, 1);
    chk("cts mark", $countones(twin), 8);
    wctl(FLG | EN);
    cyc(20);
    chk("manual mark", $countones(twin), 8);
    chk("manual rx", ctl.rx_clear, 0);
    wctl(FLG | EN | (32'h1 << `HCC_B_LOOP));
    cyc(20);
    chk("loop ignores cts", $countones(twin), 6);
    chk("loop to rx", $countones(rwin), 6);
    @(posedge clk) {cts_d, dcd_d} <= 2'b00;
  endtask
  // Echo drives the pin from the receive line, receiver still listens
  task automatic t_echo;
    wctl(32'h1 << `HCC_B_ECHO);
    @(posedge clk) rx_lvl <= 1'b0;
    cyc(20);
    chk("echo txd", $countones(twin), 0);
    chk("echo rx", $countones(rwin), 0);
    @(posedge clk) rx_lvl <= 1'b1;
  endtask
  // Preamble replaces idle fill a programmed number of times
  task automatic t_prmb;
    logic [1:0] r;
    axi_wr(`HCC_ADDR_PRMB, 32'h00000400, r);
    wctl(32'h1 << `HCC_B_PRMB);
    cyc(20);
    chk("preamble sent", twin, 8'h00);
    cyc(40);
    chk("preamble ends", $countones(twin), 8);
    wctl(32'h0);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    {rst_n, awv, wv, bry, arv, rry, cts_d, dcd_d, rclr} = '0;
    {rx_fr, tx_own, rx_own} = '0;
    {awa, ara, wd} = '0;
    {wst, rx_lvl} = {4'hF, 1'b1};
    error_cnt = 0;
    num_checks = 0;
    disc_cnt = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_idle();
    t_dma();
    t_dtr();
    t_abort(1'b0, 8'd8);
    t_abort(1'b1, 8'd16);
    t_discard();
    t_modem();
    t_echo();
    t_prmb();
    summarize();
  end
endmodule
